// ### hdl/pfs_top.sv
// Functional notes
// [R1] 3-bit code routes comparator input to pad
// [R2] PA6 function: gpio, timer0 out, comparator
// [R3] PA5 bit: gpio or current-sense input
// [R4] PA4 function: gpio, standard timer, comparator
// [R5] PA3 bit: gpio or comparator input
// [R6] PA1 function: gpio, compact timer, comparator
// [R7] PC1 bit: gpio or timer1 output
// [R8] PB3..PB0 bits select comparator input
// [R9] PA7 bit: gpio or reference input
// [R10] PB7..PB4 bits select segment lines
// [R11] selection registers reset zero, unused read zero
// [R12] software selects pad before enabling peripheral
// [R13] reset sets data latches and directions high
// [R14] new output drives latch reset one
// [R15] bit set/clear reads, modifies, writes byte
// [R16] falling port A edge wakes halted device
// [R17] wake only for gpio pin while halted
// [R18] direction one input, zero push-pull output
// [R19] output pin reads latch, not pad
// [R20] alternate function takes pad from latch
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "pfs_map.svh"
module pfs_top #(
  parameter int PC_WIDTH = `PFS_PC_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic halted_i,
  output logic wake_o,
  input wire logic [7:0] pa_pad_i,
  input wire logic [7:0] pb_pad_i,
  input wire logic [PC_WIDTH-1:0] pc_pad_i,
  output logic [7:0] pa_pad_o,
  output logic [7:0] pa_pad_oe_o,
  output logic [7:0] pb_pad_o,
  output logic [7:0] pb_pad_oe_o,
  output logic [PC_WIDTH-1:0] pc_pad_o,
  output logic [PC_WIDTH-1:0] pc_pad_oe_o,
  input wire logic periodic_timer0_out_i,
  input wire logic periodic_timer1_out_i,
  input wire logic standard_timer_out_i,
  input wire logic compact_timer_out_i,
  input wire logic [3:0] segment_common_lines_i,
  output logic protection_comparator_input_o,
  output logic protection_current_sense_input_o,
  output logic reference_voltage_input_o,
  output logic standard_timer_pin_o,
  output logic standard_timer_clock_in_o,
  output logic compact_timer_clock_in_o,
  output logic periodic_timer0_clock_in_o,
  output logic external_irq0_o,
  output logic external_irq1_o
);
  import pfs_pkg::*;
  // ==========================================================
  // registers
  logic [2:0] comparator_source_code;
  logic [7:0] port_a_function_select;
  logic [5:0] port_bc_function_select;
  logic [3:0] segment_line_function_select;
  logic [7:0] pa_latch, pb_latch, pa_dir, pb_dir, port_a_wake_enable;
  logic [PC_WIDTH-1:0] pc_latch, pc_dir;
  logic [7:0] pa_sync1, pa_sync2, pb_sync1, pb_sync2, pa_prev;
  logic [PC_WIDTH-1:0] pc_sync1, pc_sync2;
  logic [7:0] bitop_reg;
  logic [7:0] pa_gpio, pb_gpio;
  logic [7:0] next_pa_out, next_pa_oe, next_pb_out, next_pb_oe;
  logic [PC_WIDTH-1:0] next_pc_out, next_pc_oe;
  logic next_cmp;
  logic [7:0] next_wake;
  logic wr_en;
  pfs_fn_type pa6_function_code, pa4_function_code, pa1_function_code;
  pfs_rmw_if rmw ();

  assign pa6_function_code = pfs_fn_type'(port_a_function_select[`PFS_PA6_LSB +: 2]);
  assign pa4_function_code = pfs_fn_type'(port_a_function_select[`PFS_PA4_LSB +: 2]);
  assign pa1_function_code = pfs_fn_type'(port_a_function_select[`PFS_PA1_LSB +: 2]);
  // one-cycle access phase; the slave answers at the first access edge
  assign wr_en = psel_i && penable_i && pwrite_i && ce_i;

  // port read: an output pin returns its latch, an input the synced pad
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pad);
    port_view = (dir & pad) | (~dir & lat); // [R19]
  endfunction

  // ==========================================================
  // pad synchronisers, pads come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_sync1 <= 8'hFF;
      pa_sync2 <= 8'hFF;
      pb_sync1 <= 8'hFF;
      pb_sync2 <= 8'hFF;
      pc_sync1 <= '1;
      pc_sync2 <= '1;
      pa_prev <= 8'hFF;
    end else if (ce_i) begin
      pa_sync1 <= pa_pad_i;
      pa_sync2 <= pa_sync1;
      pb_sync1 <= pb_pad_i;
      pb_sync2 <= pb_sync1;
      pc_sync1 <= pc_pad_i;
      pc_sync2 <= pc_sync1;
      pa_prev <= pa_sync2;
    end
  end

  // ==========================================================
  // selection registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_source_code <= 3'h0; // [R11]
      port_a_function_select <= `PFS_RST_SEL; // [R11]
      port_bc_function_select <= 6'h00; // [R11]
      segment_line_function_select <= 4'h0; // [R11]
      port_a_wake_enable <= `PFS_RST_WAKE;
      bitop_reg <= 8'h00;
    end else if (wr_en) begin
      unique case (paddr_i)
        `PFS_OFF_CMP_SRC: comparator_source_code <= pwdata_i[2:0];
        `PFS_OFF_PA_FUNC: port_a_function_select <= pwdata_i[7:0];
        `PFS_OFF_PBC_FUNC: port_bc_function_select <= pwdata_i[5:0];
        `PFS_OFF_SEG_FUNC: segment_line_function_select <= pwdata_i[3:0];
        `PFS_OFF_PA_WAKE: port_a_wake_enable <= pwdata_i[7:0];
        `PFS_OFF_BITOP: bitop_reg <= pwdata_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // bit-op engine hookup; a request while busy starts nothing but still overwrites bitop_reg
  assign rmw.start = wr_en && (paddr_i == `PFS_OFF_BITOP) && !rmw.busy;
  assign rmw.set_bit = bitop_reg[`PFS_BITOP_SET];
  assign rmw.bit_sel = bitop_reg[2:0];
  always_comb begin
    unique case ({bitop_reg[`PFS_BITOP_DIR], bitop_reg[5:4]})
      3'h0: rmw.read_data = port_view(pa_dir, pa_latch, pa_sync2); // [R15]
      3'h1: rmw.read_data = port_view(pb_dir, pb_latch, pb_sync2);
      3'h2: rmw.read_data = 8'(port_view(8'(pc_dir), 8'(pc_latch), 8'(pc_sync2)));
      3'h4: rmw.read_data = pa_dir;
      3'h5: rmw.read_data = pb_dir;
      3'h6: rmw.read_data = 8'(pc_dir);
      default: rmw.read_data = 8'h00;
    endcase
  end
  pfs_rmw u_rmw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .rmw(rmw)
  );

  // ==========================================================
  // data latches and direction registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_latch <= `PFS_RST_PORT; // [R13]
      pb_latch <= `PFS_RST_PORT; // [R13]
      pc_latch <= '1; // [R13]
      pa_dir <= `PFS_RST_PORT; // [R13]
      pb_dir <= `PFS_RST_PORT; // [R13]
      pc_dir <= '1; // [R13]
    end else if (ce_i) begin
      if (wr_en) begin
        unique case (paddr_i)
          `PFS_OFF_PA_DATA: pa_latch <= pwdata_i[7:0];
          `PFS_OFF_PB_DATA: pb_latch <= pwdata_i[7:0];
          `PFS_OFF_PC_DATA: pc_latch <= pwdata_i[PC_WIDTH-1:0];
          `PFS_OFF_PA_DIR: pa_dir <= pwdata_i[7:0]; // [R18]
          `PFS_OFF_PB_DIR: pb_dir <= pwdata_i[7:0];
          `PFS_OFF_PC_DIR: pc_dir <= pwdata_i[PC_WIDTH-1:0];
          default: begin
          end
        endcase
      end
      if (rmw.write_strobe) begin
        unique case ({bitop_reg[`PFS_BITOP_DIR], bitop_reg[5:4]})
          3'h0: pa_latch <= rmw.write_data; // [R15]
          3'h1: pb_latch <= rmw.write_data;
          3'h2: pc_latch <= rmw.write_data[PC_WIDTH-1:0];
          3'h4: pa_dir <= rmw.write_data;
          3'h5: pb_dir <= rmw.write_data;
          3'h6: pc_dir <= rmw.write_data[PC_WIDTH-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // pad drive: gpio from latch, alternate from peripheral
  always_comb begin
    next_pa_out = pa_latch; // [R14]
    next_pa_oe = ~pa_dir; // [R18]
    next_pb_out = pb_latch;
    next_pb_oe = ~pb_dir;
    next_pc_out = pc_latch;
    next_pc_oe = ~pc_dir;
    pa_gpio = 8'hFF;
    pb_gpio = 8'hFF;
    // pa6
    unique case (pa6_function_code)
      PFS_FN_GPIO: begin
      end
      PFS_FN_PERIPH: begin
        next_pa_out[6] = periodic_timer0_out_i; // [R2] [R20]
        next_pa_oe[6] = 1'b1;
        pa_gpio[6] = 1'b0;
      end
      PFS_FN_CMP, PFS_FN_CMP_ALT: begin
        next_pa_oe[6] = 1'b0; // [R2] [R20]
        pa_gpio[6] = 1'b0;
      end
    endcase
    // pa4: standard timer pin is two-way, direction follows the port bit
    unique case (pa4_function_code)
      PFS_FN_GPIO: begin
      end
      PFS_FN_PERIPH: begin
        next_pa_out[4] = standard_timer_out_i; // [R4] [R20]
        pa_gpio[4] = 1'b0;
      end
      PFS_FN_CMP, PFS_FN_CMP_ALT: begin
        next_pa_oe[4] = 1'b0; // [R4]
        pa_gpio[4] = 1'b0;
      end
    endcase
    unique case (pa1_function_code)
      PFS_FN_GPIO: begin
      end
      PFS_FN_PERIPH: begin
        next_pa_out[1] = compact_timer_out_i; // [R6] [R20]
        next_pa_oe[1] = 1'b1;
        pa_gpio[1] = 1'b0;
      end
      PFS_FN_CMP, PFS_FN_CMP_ALT: begin
        next_pa_oe[1] = 1'b0; // [R6]
        pa_gpio[1] = 1'b0;
      end
    endcase
    if (port_a_function_select[`PFS_PA5_BIT]) begin
      next_pa_oe[5] = 1'b0; // [R3]
      pa_gpio[5] = 1'b0;
    end
    if (port_a_function_select[`PFS_PA3_BIT]) begin
      next_pa_oe[3] = 1'b0; // [R5]
      pa_gpio[3] = 1'b0;
    end
    if (port_bc_function_select[`PFS_PA7_BIT]) begin
      next_pa_oe[7] = 1'b0; // [R9]
      pa_gpio[7] = 1'b0;
    end
    if (port_bc_function_select[`PFS_PC1_BIT]) begin
      next_pc_out[1] = periodic_timer1_out_i; // [R7]
      next_pc_oe[1] = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      if (port_bc_function_select[`PFS_PB_CMP_LSB + i]) begin
        next_pb_oe[i] = 1'b0; // [R8]
        pb_gpio[i] = 1'b0;
      end
      if (segment_line_function_select[i]) begin
        next_pb_out[4 + i] = segment_common_lines_i[i]; // [R10]
        next_pb_oe[4 + i] = 1'b1;
        pb_gpio[4 + i] = 1'b0;
      end
    end
  end

  // comparator routing and wake detect
  always_comb begin
    unique case (comparator_source_code)
      3'h0: next_cmp = pb_sync2[0] & ~pb_gpio[0]; // [R1]
      3'h1: next_cmp = pb_sync2[1] & ~pb_gpio[1];
      3'h2: next_cmp = pb_sync2[2] & ~pb_gpio[2];
      3'h3: next_cmp = pb_sync2[3] & ~pb_gpio[3];
      3'h4: next_cmp = pa_sync2[6] & pa6_function_code[1]; // [R1]
      3'h5: next_cmp = pa_sync2[3] & port_a_function_select[`PFS_PA3_BIT];
      3'h6: next_cmp = pa_sync2[1] & pa1_function_code[1];
      3'h7: next_cmp = pa_sync2[4] & pa4_function_code[1];
    endcase
    next_wake = pa_prev & ~pa_sync2 & port_a_wake_enable & pa_gpio; // [R16] [R17]
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_pad_o <= 8'hFF;
      pa_pad_oe_o <= 8'h00;
      pb_pad_o <= 8'hFF;
      pb_pad_oe_o <= 8'h00;
      pc_pad_o <= '1;
      pc_pad_oe_o <= '0;
      protection_comparator_input_o <= 1'b0;
      protection_current_sense_input_o <= 1'b0;
      reference_voltage_input_o <= 1'b0;
      standard_timer_pin_o <= 1'b0;
      standard_timer_clock_in_o <= 1'b0;
      compact_timer_clock_in_o <= 1'b0;
      periodic_timer0_clock_in_o <= 1'b0;
      external_irq0_o <= 1'b0;
      external_irq1_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      pa_pad_o <= next_pa_out;
      pa_pad_oe_o <= next_pa_oe;
      pb_pad_o <= next_pb_out;
      pb_pad_oe_o <= next_pb_oe;
      pc_pad_o <= next_pc_out;
      pc_pad_oe_o <= next_pc_oe;
      protection_comparator_input_o <= next_cmp; // [R1]
      protection_current_sense_input_o <= pa_sync2[5] & port_a_function_select[5]; // [R3]
      reference_voltage_input_o <= pa_sync2[7] & port_bc_function_select[0]; // [R9]
      standard_timer_pin_o <= pa_sync2[4] & (pa4_function_code == PFS_FN_PERIPH); // [R4]
      standard_timer_clock_in_o <= pa_sync2[5] & pa_gpio[5]; // [R3]
      external_irq1_o <= pa_sync2[5] & pa_gpio[5]; // [R3]
      compact_timer_clock_in_o <= pa_sync2[3] & pa_gpio[3]; // [R5]
      external_irq0_o <= pa_sync2[3] & pa_gpio[3]; // [R5]
      periodic_timer0_clock_in_o <= pa_sync2[7] & pa_gpio[7]; // [R9]
      wake_o <= halted_i && (next_wake != 8'h00); // [R16] [R17]
    end
  end

  // ==========================================================
  // apb read data and answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= psel_i && !penable_i; // ready in the first access cycle
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (paddr_i)
          `PFS_OFF_CMP_SRC: prdata_o <= {29'h0, comparator_source_code}; // [R11]
          `PFS_OFF_PA_FUNC: prdata_o <= {24'h0, port_a_function_select};
          `PFS_OFF_PBC_FUNC: prdata_o <= {26'h0, port_bc_function_select};
          `PFS_OFF_SEG_FUNC: prdata_o <= {28'h0, segment_line_function_select};
          `PFS_OFF_PA_DATA: prdata_o <= {24'h0, port_view(pa_dir, pa_latch, pa_sync2)};
          `PFS_OFF_PB_DATA: prdata_o <= {24'h0, port_view(pb_dir, pb_latch, pb_sync2)};
          `PFS_OFF_PC_DATA: prdata_o <= 32'(port_view(8'(pc_dir), 8'(pc_latch), 8'(pc_sync2)));
          `PFS_OFF_PA_DIR: prdata_o <= {24'h0, pa_dir};
          `PFS_OFF_PB_DIR: prdata_o <= {24'h0, pb_dir};
          `PFS_OFF_PC_DIR: prdata_o <= 32'(pc_dir);
          `PFS_OFF_PA_WAKE: prdata_o <= {24'h0, port_a_wake_enable};
          `PFS_OFF_BITOP: prdata_o <= {24'h0, bitop_reg};
          `PFS_OFF_STATUS: prdata_o <= {31'h0, rmw.busy};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // pfs_top

// ### hdl/pfs_map.svh
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
// ==========================================================
// register byte offsets
`define PFS_OFF_CMP_SRC 12'h000
`define PFS_OFF_PA_FUNC 12'h004
`define PFS_OFF_PBC_FUNC 12'h008
`define PFS_OFF_SEG_FUNC 12'h00C
`define PFS_OFF_PA_DATA 12'h010
`define PFS_OFF_PB_DATA 12'h014
`define PFS_OFF_PC_DATA 12'h018
`define PFS_OFF_PA_DIR 12'h01C
`define PFS_OFF_PB_DIR 12'h020
`define PFS_OFF_PC_DIR 12'h024
`define PFS_OFF_PA_WAKE 12'h028
`define PFS_OFF_BITOP 12'h02C
`define PFS_OFF_STATUS 12'h030
// ==========================================================
// reset values
`define PFS_RST_SEL 8'h00
`define PFS_RST_PORT 8'hFF
`define PFS_RST_WAKE 8'h00
// ==========================================================
// field positions
`define PFS_CMP_SRC_MSB 2
`define PFS_PA6_LSB 6
`define PFS_PA5_BIT 5
`define PFS_PA4_LSB 3
`define PFS_PA3_BIT 2
`define PFS_PA1_LSB 0
`define PFS_PC1_BIT 5
`define PFS_PB_CMP_LSB 1
`define PFS_PA7_BIT 0
`define PFS_PC_WIDTH 6
// bit-op register: [2:0] bit, [5:4] port, [6] port vs direction, [7] set
`define PFS_BITOP_SET 7
`define PFS_BITOP_DIR 6
`endif

// ### hdl/pfs_pkg.sv
package pfs_pkg;
  // ==========================================================
  // pad function codes
  typedef enum logic [1:0] {
    PFS_FN_GPIO = 2'h0,
    PFS_FN_PERIPH = 2'h1,
    PFS_FN_CMP = 2'h2,
    PFS_FN_CMP_ALT = 2'h3
  } pfs_fn_type;
  typedef enum logic [1:0] {
    PFS_ST_IDLE = 2'h0,
    PFS_ST_READ = 2'h1,
    PFS_ST_WRITE = 2'h2
  } pfs_bitop_state_type;
endpackage

// ### hdl/pfs_rmw_if.sv
`timescale 1ns/10ps
interface pfs_rmw_if;
  logic start;
  logic set_bit;
  logic [2:0] bit_sel;
  logic [7:0] read_data;
  logic [7:0] write_data;
  logic write_strobe;
  logic busy;
  modport master (output start, output set_bit, output bit_sel, output read_data,
    input write_data, input write_strobe, input busy);
  modport engine (input start, input set_bit, input bit_sel, input read_data,
    output write_data, output write_strobe, output busy);
endinterface

// ### hdl/pfs_rmw.sv
`timescale 1ns/10ps
module pfs_rmw (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pfs_rmw_if.engine rmw
);
  import pfs_pkg::*;
  pfs_bitop_state_type state;
  logic [7:0] held;
  // ==========================================================
  // read the whole byte, change one bit, write the byte back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PFS_ST_IDLE;
      held <= 8'h00;
      rmw.write_strobe <= 1'b0;
      rmw.write_data <= 8'h00;
    end else if (ce_i) begin
      rmw.write_strobe <= 1'b0;
      unique case (state)
        PFS_ST_IDLE: begin
          if (rmw.start) begin
            state <= PFS_ST_READ;
          end
        end
        PFS_ST_READ: begin
          held <= rmw.read_data; // [R15]
          state <= PFS_ST_WRITE;
        end
        PFS_ST_WRITE: begin
          rmw.write_data <= held;
          rmw.write_data[rmw.bit_sel] <= rmw.set_bit; // [R15]
          rmw.write_strobe <= 1'b1;
          state <= PFS_ST_IDLE;
        end
        default: begin
          state <= PFS_ST_IDLE;
        end
      endcase
    end
  end
  assign rmw.busy = (state != PFS_ST_IDLE);
endmodule // pfs_rmw

// ### tb/pfs_far_side.sv
`timescale 1ns/10ps
// ==========================================================
// far side: pad wiring and peripheral outputs
module pfs_far_side (
  input wire logic en_i,
  input wire logic [7:0] lvl_i,
  input wire logic [7:0] pa_ext_i,
  input wire logic [7:0] pb_ext_i,
  input wire logic [5:0] pc_ext_i,
  input wire logic [7:0] pa_out_i,
  input wire logic [7:0] pa_oe_i,
  input wire logic [7:0] pb_out_i,
  input wire logic [7:0] pb_oe_i,
  input wire logic [5:0] pc_out_i,
  input wire logic [5:0] pc_oe_i,
  output logic [7:0] pa_lvl_o,
  output logic [7:0] pb_lvl_o,
  output logic [5:0] pc_lvl_o,
  output logic t0_o,
  output logic t1_o,
  output logic st_o,
  output logic ct_o,
  output logic [3:0] seg_o
);
  // a pad follows its driver while enabled, else the outside
  assign pa_lvl_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & pa_ext_i);
  assign pb_lvl_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & pb_ext_i);
  assign pc_lvl_o = (pc_oe_i & pc_out_i) | (~pc_oe_i & pc_ext_i);
  // peripherals sit low until enabled: a bad route shows as a stuck level
  assign t0_o = en_i & lvl_i[0];
  assign t1_o = en_i & lvl_i[1];
  assign st_o = en_i & lvl_i[2];
  assign ct_o = en_i & lvl_i[3];
  assign seg_o = {4{en_i}} & lvl_i[7:4];
endmodule // pfs_far_side

// ### tb/pfs_top_checker.sv
`timescale 1ns/10ps
// ==========================================================
// port checker
module pfs_top_checker #(
  parameter int PC_WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic halted_i,
  input wire logic wake_o,
  input wire logic [7:0] pa_pad_i,
  input wire logic [7:0] pb_pad_i,
  input wire logic [7:0] pa_pad_o,
  input wire logic [7:0] pa_pad_oe_o,
  input wire logic [7:0] pb_pad_oe_o,
  input wire logic [PC_WIDTH-1:0] pc_pad_oe_o,
  input wire logic protection_comparator_input_o,
  input wire logic protection_current_sense_input_o,
  input wire logic reference_voltage_input_o,
  input wire logic external_irq0_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // zero wait states: answer in the access cycle only
  property p_ready;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready missing after setup");
  property p_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_hold;
    !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst;
    $fell(rst_i) |-> pa_pad_oe_o == 8'h00 && pb_pad_oe_o == 8'h00 && pc_pad_oe_o == '0
      && pa_pad_o == 8'hFF;
  endproperty
  a_rst: assert property (p_rst) else $error("pads not idle after reset");
  // a routed input needs a candidate pad high three edges back
  property p_cmp;
    protection_comparator_input_o |-> (($past(pb_pad_i, 3) & 8'h0F) != 8'h00)
      || (($past(pa_pad_i, 3) & 8'h5A) != 8'h00);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator without pad");
  property p_sense;
    protection_current_sense_input_o |-> ($past(pa_pad_i, 3) & 8'h20) != 8'h00;
  endproperty
  a_sense: assert property (p_sense) else $error("sense input without pad");
  property p_irq0;
    external_irq0_o |-> ($past(pa_pad_i, 3) & 8'h08) != 8'h00;
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 without pad");
  property p_vref;
    reference_voltage_input_o |-> ($past(pa_pad_i, 3) & 8'h80) != 8'h00;
  endproperty
  a_vref: assert property (p_vref) else $error("reference input without pad");
  property p_wake;
    !halted_i |=> !wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake while running");
  c_wake: cover property (wake_o);
  c_cmp: cover property (protection_comparator_input_o);
  c_read: cover property (psel_i && !pwrite_i && pready_o);
endmodule // pfs_top_checker

bind pfs_top pfs_top_checker #(.PC_WIDTH(PC_WIDTH)) i_chk (.*);

// ### tb/pin_function_selector_test.sv
`timescale 1ns/10ps
// ==========================================================
// bench top
module pin_function_selector_test;
  logic clk_i, rst_i, ce_i, psel_i, penable_i, pwrite_i, halted_i, en;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r, q;
  logic pready_o, pslverr_o, wake_o, periodic_timer0_out_i, periodic_timer1_out_i;
  logic standard_timer_out_i, compact_timer_out_i, external_irq0_o, external_irq1_o;
  logic protection_comparator_input_o, protection_current_sense_input_o;
  logic reference_voltage_input_o, standard_timer_pin_o, standard_timer_clock_in_o;
  logic compact_timer_clock_in_o, periodic_timer0_clock_in_o;
  logic [3:0] segment_common_lines_i;
  logic [7:0] pa_pad_i, pb_pad_i, pa_pad_o, pa_pad_oe_o, pb_pad_o, pb_pad_oe_o, lvl, v, oh;
  logic [5:0] pc_pad_i, pc_pad_o, pc_pad_oe_o;
  logic [7:0] ext [3];
  // register model: sel 0..3, data 4..6, dir 7..9, wake 10, bit-op 11, status 12
  logic [7:0] m [14] = '{0, 0, 0, 0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 0, 0, 0, 0};
  logic [7:0] msk [14] = '{8'h07, 8'hFF, 8'h3F, 8'h0F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF,
    8'h3F, 8'hFF, 0, 0, 0};
  int fail_count = 0, checks_done = 0, i, p, k, c, t, b, n;
  int pin [8] = '{0, 1, 2, 3, 6, 3, 1, 4};
  int sl [5] = '{0, 1, 2, 3, 10};

  pfs_top i_dut (.*);
  pfs_far_side i_far (.en_i(en), .lvl_i(lvl), .pa_ext_i(ext[0]), .pb_ext_i(ext[1]),
    .pc_ext_i(ext[2][5:0]), .pa_out_i(pa_pad_o), .pa_oe_i(pa_pad_oe_o), .pb_out_i(pb_pad_o),
    .pb_oe_i(pb_pad_oe_o), .pc_out_i(pc_pad_o), .pc_oe_i(pc_pad_oe_o), .pa_lvl_o(pa_pad_i),
    .pb_lvl_o(pb_pad_i), .pc_lvl_o(pc_pad_i), .t0_o(periodic_timer0_out_i),
    .t1_o(periodic_timer1_out_i), .st_o(standard_timer_out_i), .ct_o(compact_timer_out_i),
    .seg_o(segment_common_lines_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================
  // helpers
  task automatic close_out;
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // port reads: input pins show the pad, output pins the latch
  function automatic logic [31:0] mdl(int j);
    logic [7:0] x;
    x = (j >= 4 && j <= 6) ? ((m[j+3] & ext[j-4]) | (~m[j+3] & m[j])) : m[j];
    return {24'h0, x & msk[j]};
  endfunction
  function automatic logic [7:0] pv(int j, bit e);
    if (j == 0) return e ? pa_pad_oe_o : pa_pad_o;
    if (j == 1) return e ? pb_pad_oe_o : pb_pad_o;
    return {2'b00, e ? pc_pad_oe_o : pc_pad_o};
  endfunction
  // request held until pready is sampled high; no latency assumed
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] qo);
    int cnt;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (pready_o !== 1'b1 && cnt < 20);
    qo = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1 || pslverr_o !== 1'b0) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic wr(int j, logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, 12'(j * 4), d, x);
    m[j] = d[7:0];
  endtask
  task automatic rd(int j);
    logic [31:0] x;
    apb(1'b0, 12'(j * 4), 32'h0, x);
    chk($sformatf("reg%0d", j), x, mdl(j));
  endtask
  task automatic idle;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic wk(int pn, logic h, logic [7:0] s, int e);
    int cnt;
    wr(1, s);
    ext[0] <= 8'hFF;
    halted_i <= h;
    idle();
    ext[0][pn] <= 1'b0;
    cnt = 0;
    repeat (10) begin
      @(posedge clk_i);
      if (wake_o === 1'b1) cnt++;
    end
    chk("wake", cnt, e);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {ce_i, rst_i, psel_i, penable_i, pwrite_i, halted_i, en} = 7'b1100000;
    {paddr_i, pwdata_i, lvl} = '0;
    ext = '{8'h5A, 8'hC3, 8'h15};
    void'($urandom(32'h6f3f));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 14; i++) if (i != 11) rd(i);
    // untouched latch drives high, then random latch and direction
    for (p = 0; p < 3; p++) begin
      wr(7 + p, 0);
      idle();
      chk("drive_hi", {pv(p, 1), pv(p, 0)}, {msk[4+p], msk[4+p]});
      wr(4 + p, $urandom);
      wr(7 + p, $urandom);
      idle();
      chk("oe", pv(p, 1), ~m[7+p] & msk[4+p]);
      chk("drive", pv(p, 0) & pv(p, 1), m[4+p] & ~m[7+p] & msk[4+p]);
      rd(4 + p);
    end
    // bit set/clear rewrites the byte as read
    repeat (6) begin
      r = $urandom;
      p = int'(r[5:4]) % 3;
      b = (p == 2) ? int'(r[2:0]) % 6 : int'(r[2:0]);
      t = r[6] ? 7 + p : 4 + p;
      v = r[6] ? m[t] : 8'(mdl(t));
      v[b] = r[7];
      wr(11, {24'h0, r[7], r[6], 2'(p), 1'b0, 3'(b)});
      n = 0;
      do begin
        apb(1'b0, 12'h030, 32'h0, q);
        n++;
      end while (q[0] !== 1'b0 && n < 10);
      chk("busy", q & 32'h1, 32'h0);
      m[t] = v;
      rd(t);
      if (!r[6]) begin
        wr(7 + p, 0);
        idle();
        chk("rmw_pad", pv(p, 0), m[t] & msk[t]);
      end
    end
    for (i = 0; i < 5; i++) begin
      wr(sl[i], $urandom);
      rd(sl[i]);
    end
    // select first, enable after, disable before leaving
    wr(7, 8'hEF);
    wr(8, 8'hFF);
    wr(9, 8'hFF);
    wr(1, 8'h49);
    wr(2, 8'h20);
    wr(3, 8'h0F);
    en <= 1'b1;
    for (k = 0; k < 2; k++) begin
      lvl <= k ? ~lvl : 8'($urandom);
      idle();
      chk("pa_alt", {pa_pad_oe_o & 8'h52, pa_pad_o & 8'h52},
        {8'h52, 1'b0, lvl[0], 1'b0, lvl[2], 2'b00, lvl[3], 1'b0});
      chk("st_in", standard_timer_pin_o, lvl[2]);
      chk("pc_alt", {pc_pad_oe_o[1], pc_pad_o[1]}, {1'b1, lvl[1]});
      chk("seg", {pb_pad_oe_o[7:4], pb_pad_o[7:4]}, {4'hF, lvl[7:4]});
    end
    en <= 1'b0;
    // every comparator source, pads outputs first
    wr(7, 0);
    wr(8, 0);
    wr(1, 8'hB6);
    wr(2, 8'h1F);
    wr(3, 0);
    idle();
    chk("cmp_oe", {pa_pad_oe_o & 8'hFA, pb_pad_oe_o & 8'h0F}, 0);
    for (c = 0; c < 8; c++) begin
      wr(0, c);
      for (k = 0; k < 2; k++) begin
        oh = 8'h01 << pin[c];
        ext[0] <= (c > 3) ? (k ? oh : ~oh) : 8'h00;
        ext[1] <= (c < 4) ? (k ? oh : ~oh) : 8'h00;
        idle();
        chk("cmp", protection_comparator_input_o, 32'(k));
        chk("alt_in", {protection_current_sense_input_o, reference_voltage_input_o,
          external_irq0_o, external_irq1_o, standard_timer_clock_in_o, compact_timer_clock_in_o,
          periodic_timer0_clock_in_o, standard_timer_pin_o},
          {ext[0][5], ext[0][7], 6'h00});
      end
    end
    // wake: enabled gpio pin while halted only
    wr(0, 0);
    wr(2, 0);
    wr(7, 8'hFF);
    wr(10, 8'h09);
    wk(0, 1'b1, 8'h00, 1);
    wk(1, 1'b1, 8'h00, 0);
    wk(3, 1'b1, 8'h04, 0);
    wk(0, 1'b0, 8'h00, 0);
    close_out();
  end
endmodule // pin_function_selector_test
